// [shared/ide_dma_consts.svh]
`ifndef IDE_DMA_CONSTS_SVH
`define IDE_DMA_CONSTS_SVH
// Register offsets of the primary channel, and the stride to the secondary.
`define REG_CHANNEL_COMMAND   4'h0
`define REG_CHANNEL_STATUS    4'h2
`define REG_TABLE_BASE        4'h4
`define SEC_STRIDE            4'h8
// Command register fields.
`define CMD_START_BIT         0
`define CMD_TO_MEM_BIT        3
// Status register fields.
`define STA_ACTIVE_BIT        0
`define STA_ERROR_BIT         1
`define STA_IRQ_BIT           2
`define STA_CAP0_BIT          5
`define STA_CAP1_BIT          6
// Table base reset value and write mask.
`define TABLE_BASE_RESET      32'h0000_0000
`define TABLE_BASE_MASK       32'hFFFF_FFFC
// Descriptor: word 0 region address, word 1 byte count and end flag.
`define DESC_EOT_BIT          31
`define DESC_STEP             12'h004
`define PAGE_BITS             12
`define WORD_STEP             32'h0000_0004
`endif

// [shared/ide_dma_pkg.sv]
package ide_dma_pkg;
    // Channel sequencer states.
    typedef enum logic [2:0] {
        CH_IDLE,
        CH_DESC_ADDR,
        CH_DESC_CNT,
        CH_WAIT_DRIVE,
        CH_MEM
    } chan_state_t;
endpackage : ide_dma_pkg

// [design/ide_dma_channel.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ide_dma_consts.svh"
module ide_dma_channel (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        start_set_i,
    input  wire logic        start_clr_i,
    input  wire logic        to_mem_i,
    input  wire logic [31:0] table_base_i,
    input  wire logic        irq_clr_i,
    input  wire logic        err_clr_i,
    input  wire logic        drive_irq_i,
    input  wire logic        drive_req_i,
    input  wire logic [31:0] drive_rdata_i,
    output logic             drive_ack_o,
    output logic [31:0]      drive_wdata_o,
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic [31:0]      mem_addr_o,
    output logic [31:0]      mem_wdata_o,
    input  wire logic        mem_done_i,
    input  wire logic        mem_abort_i,
    input  wire logic [31:0] mem_rdata_i,
    output logic             active_o,
    output logic             error_o,
    output logic             irq_o
);
    ide_dma_pkg::chan_state_t state;
    logic [31:0] desc_ptr;
    logic [31:0] region_addr;
    logic [13:0] words_left;
    logic        last_region;
    logic        irq_prev;
    logic        finish;

    // The region ends when its last word completes cleanly.
    assign finish = (state == ide_dma_pkg::CH_MEM) && mem_done_i && !mem_abort_i
                    && (words_left == 14'h0001);

    // The memory request is a level held by the state until the arbiter answers.
    always_comb begin
        mem_req_o   = 1'b0;
        mem_we_o    = 1'b0;
        mem_addr_o  = region_addr;
        case (state)
            ide_dma_pkg::CH_DESC_ADDR: begin
                mem_req_o  = 1'b1;
                mem_addr_o = desc_ptr;
            end
            ide_dma_pkg::CH_DESC_CNT: begin
                mem_req_o  = 1'b1;
                mem_addr_o = {desc_ptr[31:`PAGE_BITS], desc_ptr[`PAGE_BITS-1:0] + `DESC_STEP};
            end
            ide_dma_pkg::CH_MEM: begin
                mem_req_o = 1'b1;
                mem_we_o  = to_mem_i;
            end
            default: begin
                mem_req_o = 1'b0;
            end
        endcase
    end

    // Sequencer: walk the list, one word per drive request.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state       <= ide_dma_pkg::CH_IDLE;
            desc_ptr    <= 32'h0000_0000;
            region_addr <= 32'h0000_0000;
            words_left  <= 14'h0000;
            last_region <= 1'b0;
            mem_wdata_o <= 32'h0000_0000;
            drive_wdata_o <= 32'h0000_0000;
            drive_ack_o <= 1'b0;
        end else begin
            drive_ack_o <= 1'b0;
            if (start_clr_i) begin
                state <= ide_dma_pkg::CH_IDLE;
            end else if (start_set_i) begin
                desc_ptr <= table_base_i;
                state    <= ide_dma_pkg::CH_DESC_ADDR;
            end else begin
                case (state)
                    ide_dma_pkg::CH_DESC_ADDR: begin
                        if (mem_done_i) begin
                            region_addr <= mem_rdata_i & `TABLE_BASE_MASK;
                            state <= mem_abort_i ? ide_dma_pkg::CH_IDLE
                                                 : ide_dma_pkg::CH_DESC_CNT;
                        end
                    end
                    ide_dma_pkg::CH_DESC_CNT: begin
                        if (mem_done_i) begin
                            // A zero count stands for the full 64 Kbyte region.
                            words_left  <= mem_rdata_i[15:2];
                            last_region <= mem_rdata_i[`DESC_EOT_BIT];
                            state <= mem_abort_i ? ide_dma_pkg::CH_IDLE
                                                 : ide_dma_pkg::CH_WAIT_DRIVE;
                        end
                    end
                    ide_dma_pkg::CH_WAIT_DRIVE: begin
                        // A request beside our own ack is the one just answered.
                        if (drive_req_i && !drive_ack_o) begin
                            mem_wdata_o <= drive_rdata_i;
                            drive_ack_o <= to_mem_i;
                            state       <= ide_dma_pkg::CH_MEM;
                        end
                    end
                    ide_dma_pkg::CH_MEM: begin
                        if (mem_done_i) begin
                            if (mem_abort_i) begin
                                state <= ide_dma_pkg::CH_IDLE;
                            end else begin
                                if (!to_mem_i) begin
                                    drive_wdata_o <= mem_rdata_i;
                                    drive_ack_o   <= 1'b1;
                                end
                                region_addr <= region_addr + `WORD_STEP;
                                words_left  <= words_left - 14'h0001;
                                if (finish && last_region) begin
                                    state <= ide_dma_pkg::CH_IDLE;
                                end else if (finish) begin
                                    // The table never leaves its 4 Kbyte page.
                                    desc_ptr[`PAGE_BITS-1:0] <= desc_ptr[`PAGE_BITS-1:0]
                                                               + `DESC_STEP + `DESC_STEP;
                                    state <= ide_dma_pkg::CH_DESC_ADDR;
                                end else begin
                                    state <= ide_dma_pkg::CH_WAIT_DRIVE;
                                end
                            end
                        end
                    end
                    default: begin
                        state <= ide_dma_pkg::CH_IDLE;
                    end
                endcase
            end
        end
    end

    // Active flag: set by start, cleared by stop, end of table or a fault.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            active_o <= 1'b0;
        end else if (start_clr_i) begin
            active_o <= 1'b0;
        end else if (start_set_i) begin
            active_o <= 1'b1;
        end else if ((state != ide_dma_pkg::CH_IDLE) && mem_done_i && mem_abort_i) begin
            active_o <= 1'b0;
        end else if (finish && last_region) begin
            active_o <= 1'b0;
        end
    end

    // Error flag: the set wins over a software clear in the same cycle.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            error_o <= 1'b0;
        end else if ((state != ide_dma_pkg::CH_IDLE) && mem_done_i && mem_abort_i) begin
            error_o <= 1'b1;
        end else if (err_clr_i) begin
            error_o <= 1'b0;
        end
    end

    // Interrupt flag is edge set, so a clear under a held line stays clear.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_prev <= 1'b0;
            irq_o    <= 1'b0;
        end else begin
            irq_prev <= drive_irq_i;
            if (drive_irq_i && !irq_prev) begin
                irq_o <= 1'b1;
            end else if (irq_clr_i) begin
                irq_o <= 1'b0;
            end
        end
    end
endmodule : ide_dma_channel
`default_nettype wire

// [design/ide_dma_engine.sv]
// Contract
// - Running with no drive interrupt yet reads interrupt 0, active 1.
// - Interrupt with the list used up reads interrupt 1, active 0.
// - Interrupt before the last region reads interrupt 1, active 1.
// - A memory fault stops the channel with interrupt 0, active 0, error 1.
// - A table shorter than the drive transfer ends with all three flags 0.
// - The table base holds address bits 31:2; bits 1:0 read zero.
// - Each channel has a read/write table base at 04h or 0Ch, reset 0.
// - Interrupt status sets on a drive interrupt edge, clears on a 1.
// - Active sets on start, clears at end of table, stop or error.
// - Error sets on a target or master abort, clears on a 1.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ide_dma_consts.svh"
module ide_dma_engine #(
    parameter int CHANNELS = 2
) (
    input  wire logic                      clk_i,
    input  wire logic                      reset_n_i,
    input  wire logic [3:0]                reg_addr_i,
    input  wire logic [31:0]               reg_wdata_i,
    input  wire logic                      reg_write_i,
    input  wire logic                      reg_read_i,
    output logic      [31:0]               reg_rdata_o,
    input  wire logic [CHANNELS-1:0]       drive_irq_i,
    input  wire logic [CHANNELS-1:0]       drive_req_i,
    input  wire logic [CHANNELS-1:0][31:0] drive_rdata_i,
    output logic      [CHANNELS-1:0]       drive_ack_o,
    output logic      [CHANNELS-1:0][31:0] drive_wdata_o,
    output logic                           mem_req_o,
    output logic                           mem_we_o,
    output logic      [31:0]               mem_addr_o,
    output logic      [31:0]               mem_wdata_o,
    input  wire logic                      mem_ack_i,
    input  wire logic                      mem_abort_i,
    input  wire logic [31:0]               mem_rdata_i
);
    logic [CHANNELS-1:0]       cmd_start;
    logic [CHANNELS-1:0]       cmd_to_mem;
    logic [CHANNELS-1:0]       cap0;
    logic [CHANNELS-1:0]       cap1;
    logic [CHANNELS-1:0][31:0] table_base;
    logic [CHANNELS-1:0]       start_set;
    logic [CHANNELS-1:0]       start_clr;
    logic [CHANNELS-1:0]       irq_clr;
    logic [CHANNELS-1:0]       err_clr;
    logic [CHANNELS-1:0]       ch_req;
    logic [CHANNELS-1:0]       ch_we;
    logic [CHANNELS-1:0][31:0] ch_addr;
    logic [CHANNELS-1:0][31:0] ch_wdata;
    logic [CHANNELS-1:0]       ch_active;
    logic [CHANNELS-1:0]       ch_error;
    logic [CHANNELS-1:0]       ch_irq;
    logic [CHANNELS-1:0]       mem_done;
    logic                      mem_fault;
    logic [31:0]               mem_rdata;
    logic                      busy;
    logic                      owner;
    logic                      next_owner;

    // Offset of a field in channel ch.
    function automatic logic [3:0] chan_reg(input logic [3:0] base, input int ch);
        chan_reg = base + (ch[0] ? `SEC_STRIDE : 4'h0);
    endfunction : chan_reg

    // Status byte as software sees it; reserved bits read as zero.
    function automatic logic [7:0] status_byte(input logic c1, input logic c0,
                                               input logic irq, input logic err,
                                               input logic act);
        status_byte = 8'h00;
        status_byte[`STA_CAP1_BIT]   = c1;
        status_byte[`STA_CAP0_BIT]   = c0;
        status_byte[`STA_IRQ_BIT]    = irq;
        status_byte[`STA_ERROR_BIT]  = err;
        status_byte[`STA_ACTIVE_BIT] = act;
    endfunction : status_byte

    // Write decode into one-cycle strobes.
    always_comb begin
        for (int ch = 0; ch < CHANNELS; ch++) begin
            start_set[ch] = reg_write_i && (reg_addr_i == chan_reg(`REG_CHANNEL_COMMAND, ch))
                            && reg_wdata_i[`CMD_START_BIT] && !cmd_start[ch];
            start_clr[ch] = reg_write_i && (reg_addr_i == chan_reg(`REG_CHANNEL_COMMAND, ch))
                            && !reg_wdata_i[`CMD_START_BIT] && cmd_start[ch];
            irq_clr[ch]   = reg_write_i && (reg_addr_i == chan_reg(`REG_CHANNEL_STATUS, ch))
                            && reg_wdata_i[`STA_IRQ_BIT];
            err_clr[ch]   = reg_write_i && (reg_addr_i == chan_reg(`REG_CHANNEL_STATUS, ch))
                            && reg_wdata_i[`STA_ERROR_BIT];
        end
    end

    // Software-held registers.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_start  <= '0;
            cmd_to_mem <= '0;
            cap0       <= '0;
            cap1       <= '0;
            for (int ch = 0; ch < CHANNELS; ch++) begin
                table_base[ch] <= `TABLE_BASE_RESET;
            end
        end else if (reg_write_i) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                if (reg_addr_i == chan_reg(`REG_CHANNEL_COMMAND, ch)) begin
                    cmd_start[ch]  <= reg_wdata_i[`CMD_START_BIT];
                    cmd_to_mem[ch] <= reg_wdata_i[`CMD_TO_MEM_BIT];
                end
                if (reg_addr_i == chan_reg(`REG_CHANNEL_STATUS, ch)) begin
                    cap0[ch] <= reg_wdata_i[`STA_CAP0_BIT];
                    cap1[ch] <= reg_wdata_i[`STA_CAP1_BIT];
                end
                if (reg_addr_i == chan_reg(`REG_TABLE_BASE, ch)) begin
                    table_base[ch] <= reg_wdata_i & `TABLE_BASE_MASK;
                end
            end
        end
    end

    // Read data stand one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= 32'h0000_0000;
            if (reg_read_i) begin
                for (int ch = 0; ch < CHANNELS; ch++) begin
                    if (reg_addr_i == chan_reg(`REG_CHANNEL_COMMAND, ch)) begin
                        reg_rdata_o[`CMD_START_BIT]  <= cmd_start[ch];
                        reg_rdata_o[`CMD_TO_MEM_BIT] <= cmd_to_mem[ch];
                    end
                    if (reg_addr_i == chan_reg(`REG_CHANNEL_STATUS, ch)) begin
                        reg_rdata_o[7:0] <= status_byte(cap1[ch], cap0[ch], ch_irq[ch],
                                                        ch_error[ch], ch_active[ch]);
                    end
                    if (reg_addr_i == chan_reg(`REG_TABLE_BASE, ch)) begin
                        reg_rdata_o <= table_base[ch];
                    end
                end
            end
        end
    end

    // The primary channel wins a tie.
    always_comb begin
        next_owner = 1'b0;
        for (int ch = CHANNELS - 1; ch >= 0; ch--) begin
            if (ch_req[ch]) begin
                next_owner = ch[0];
            end
        end
    end

    // Memory master: busy spans the done cycle, so a stale request is never granted.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy        <= 1'b0;
            owner       <= 1'b0;
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_addr_o  <= 32'h0000_0000;
            mem_wdata_o <= 32'h0000_0000;
            mem_done    <= '0;
            mem_fault   <= 1'b0;
            mem_rdata   <= 32'h0000_0000;
        end else begin
            mem_done <= '0;
            if (!busy) begin
                if (|ch_req) begin
                    busy        <= 1'b1;
                    owner       <= next_owner;
                    mem_req_o   <= 1'b1;
                    mem_we_o    <= ch_we[next_owner];
                    mem_addr_o  <= ch_addr[next_owner];
                    mem_wdata_o <= ch_wdata[next_owner];
                end
            end else if (mem_req_o) begin
                if (mem_ack_i || mem_abort_i) begin
                    mem_req_o       <= 1'b0;
                    mem_done[owner] <= 1'b1;
                    mem_fault       <= mem_abort_i;
                    mem_rdata       <= mem_rdata_i;
                end
            end else begin
                busy <= 1'b0;
            end
        end
    end

    for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
        ide_dma_channel u_chan (
            .clk_i         (clk_i),
            .reset_n_i     (reset_n_i),
            .start_set_i   (start_set[g]),
            .start_clr_i   (start_clr[g]),
            .to_mem_i      (cmd_to_mem[g]),
            .table_base_i  (table_base[g]),
            .irq_clr_i     (irq_clr[g]),
            .err_clr_i     (err_clr[g]),
            .drive_irq_i   (drive_irq_i[g]),
            .drive_req_i   (drive_req_i[g]),
            .drive_rdata_i (drive_rdata_i[g]),
            .drive_ack_o   (drive_ack_o[g]),
            .drive_wdata_o (drive_wdata_o[g]),
            .mem_req_o     (ch_req[g]),
            .mem_we_o      (ch_we[g]),
            .mem_addr_o    (ch_addr[g]),
            .mem_wdata_o   (ch_wdata[g]),
            .mem_done_i    (mem_done[g]),
            .mem_abort_i   (mem_fault),
            .mem_rdata_i   (mem_rdata),
            .active_o      (ch_active[g]),
            .error_o       (ch_error[g]),
            .irq_o         (ch_irq[g])
        );
    end
endmodule : ide_dma_engine
`default_nettype wire

// [verif/ide_dma_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module ide_dma_properties #(
    parameter int CHANNELS = 2
) (
    input wire logic                clk_i,
    input wire logic                reset_n_i,
    input wire logic [3:0]          reg_addr_i,
    input wire logic                reg_write_i,
    input wire logic                reg_read_i,
    input wire logic [31:0]         reg_rdata_o,
    input wire logic [CHANNELS-1:0] drive_irq_i,
    input wire logic [CHANNELS-1:0] drive_ack_o,
    input wire logic                mem_req_o,
    input wire logic                mem_we_o,
    input wire logic [31:0]         mem_addr_o,
    input wire logic [31:0]         mem_wdata_o,
    input wire logic                mem_ack_i,
    input wire logic                mem_abort_i
);
    // One clock domain for every property.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence s_rd_status;
        reg_read_i && reg_addr_i[2:0] == 3'h2;
    endsequence
    // Quiet cycles keep a clear from masking the edge.
    sequence s_irq0_rise;
        $rose(drive_irq_i[0]) ##1 (!reg_write_i) [*3];
    endsequence
    property p_rdata_idle;
        !reg_read_i |=> reg_rdata_o == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
    property p_unmapped;
        reg_read_i && !(reg_addr_i inside {4'h0, 4'h2, 4'h4, 4'h8, 4'hA, 4'hC})
            |=> reg_rdata_o == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_base_align;
        reg_read_i && reg_addr_i[2:0] == 3'h4 |=> reg_rdata_o[1:0] == 2'b00;
    endproperty
    a_base_align: assert property (p_base_align) else $error("base bits 1:0 set");
    property p_status_bits;
        s_rd_status |=> !(reg_rdata_o[1] && reg_rdata_o[0]) && reg_rdata_o[4:3] == 2'b00
            && reg_rdata_o[31:7] == 25'h0000000;
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("bad status bits");
    property p_irq_set;
        s_irq0_rise ##1 (reg_read_i && reg_addr_i == 4'h2) |=> reg_rdata_o[2];
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq not set");
    property p_mem_hold;
        mem_req_o && !mem_ack_i && !mem_abort_i |=> mem_req_o && $stable(mem_addr_o)
            && $stable(mem_we_o) && $stable(mem_wdata_o);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("memory request moved");
    property p_mem_drop;
        mem_req_o && (mem_ack_i || mem_abort_i) |=> !mem_req_o;
    endproperty
    a_mem_drop: assert property (p_mem_drop) else $error("memory request held");
    property p_ack_pulse;
        drive_ack_o != '0 |=> (drive_ack_o & $past(drive_ack_o)) == '0;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("drive ack too long");
endmodule : ide_dma_properties
`default_nettype wire

// [verif/ide_dma_far_side.sv]
`timescale 1ns/10ps
`default_nettype none
module ide_dma_far_side (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic [31:0] mem_addr_i,
    input  wire logic [31:0] mem_wdata_i,
    output logic             mem_ack_o,
    output logic             mem_abort_o,
    output logic [31:0]      mem_rdata_o,
    input  wire logic [1:0]  drive_ack_i,
    output logic [1:0]       drive_req_o
);
    logic [31:0] mem [0:255];
    int          words [2];
    int          lat = 0;
    int          wait_cnt;
    logic [31:0] abort_addr = 32'hFFFF_FFFF;
    // Memory answers after lat cycles, or aborts at abort_addr.
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mem_ack_o <= 1'b0;
            mem_abort_o <= 1'b0;
            wait_cnt <= 0;
        end else begin
            mem_ack_o <= 1'b0;
            mem_abort_o <= 1'b0;
            if (mem_req_i && !mem_ack_o && !mem_abort_o) begin
                wait_cnt <= (wait_cnt >= lat) ? 0 : wait_cnt + 1;
                if (wait_cnt >= lat && mem_addr_i === abort_addr) begin
                    mem_abort_o <= 1'b1;
                end else if (wait_cnt >= lat) begin
                    mem_ack_o <= 1'b1;
                    if (mem_we_i) begin
                        mem[mem_addr_i[9:2]] <= mem_wdata_i;
                    end
                end
            end
        end
    end
    // Outside the ack cycle the data show the inverse.
    assign mem_rdata_o = mem_ack_o ? mem[mem_addr_i[9:2]] : ~mem[mem_addr_i[9:2]];
    // Each drive asks while it has words left.
    for (genvar c = 0; c < 2; c++) begin : g_drive
        always @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                drive_req_o[c] <= 1'b0;
            end else if (drive_ack_i[c]) begin
                drive_req_o[c] <= 1'b0;
                words[c] <= words[c] - 1;
            end else begin
                drive_req_o[c] <= words[c] > 0;
            end
        end
    end
endmodule : ide_dma_far_side
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk_i = 1'b0, reset_n_i = 1'b0, reg_write_i = 1'b0, reg_read_i = 1'b0;
    logic mem_req_o, mem_we_o, mem_ack_i, mem_abort_i;
    logic [3:0] reg_addr_i = 4'h0;
    logic [1:0] drive_irq_i = 2'h0, drive_req_i, drive_ack_o;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, v, mem_addr_o, mem_wdata_o, mem_rdata_i;
    logic [1:0][31:0] drive_rdata_i, drive_wdata_o;
    logic [31:0] got [$];
    int fail_count = 0;
    int num_checks = 0;
    // Drive word: channel and words left, inverted when idle.
    for (genvar c = 0; c < 2; c++) begin : g_pat
        assign drive_rdata_i[c] = {32{~drive_req_i[c]}} ^ (32'hC000_0000 + 32'(c * 256)
            + 32'(far.words[c]));
    end
    always #25 clk_i = ~clk_i;
    ide_dma_engine #(.CHANNELS(2)) DUT (.*);
    ide_dma_far_side far (.clk_i(clk_i), .reset_n_i(reset_n_i), .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .mem_ack_o(mem_ack_i), .mem_abort_o(mem_abort_i), .mem_rdata_o(mem_rdata_i),
        .drive_ack_i(drive_ack_o), .drive_req_o(drive_req_i));
    // Words handed to the primary drive.
    always @(posedge clk_i) if (drive_ack_o[0] === 1'b1) got.push_back(drive_wdata_o[0]);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_write_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input string what, input logic [31:0] exp);
        @(posedge clk_i);
        reg_read_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1 v = reg_rdata_o;
        if (what != "") check(what, v, exp);
    endtask : rd
    // Polls status until active drops.
    task automatic wait_idle(input logic [3:0] a);
        v = 32'h1;
        repeat (100) if (v[0] !== 1'b0) rd(a, "", 32'h0);
    endtask : wait_idle
    task automatic irq_edge(input int c);
        @(posedge clk_i);
        drive_irq_i[c] <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask : irq_edge
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(4'h4, "base0 reset", 32'h0);
        rd(4'hC, "base1 reset", 32'h0);
        wr(4'h4, 32'hFFFF_FFFF);
        rd(4'h4, "base0 bits", 32'hFFFF_FFFC);
        wr(4'hC, 32'h0000_1003);
        rd(4'hC, "base1 bits", 32'h0000_1000);
        wr(4'h6, 32'hFFFF_FFFF);
        rd(4'h6, "unmapped", 32'h0);
        $display("Test registers done");
        // Table at 0x100: two regions, the last ends the table.
        far.mem[64] = 32'h0000_0200;
        far.mem[65] = 32'h0000_0008;
        far.mem[66] = 32'h0000_0300;
        far.mem[67] = 32'h8000_0004;
        far.mem[128] = 32'hA000_0000;
        far.mem[129] = 32'hA000_0001;
        far.mem[192] = 32'hB000_0000;
        far.words[0] = 3;
        far.lat = 2;
        wr(4'h4, 32'h0000_0100);
        wr(4'h0, 32'h0000_0001);
        rd(4'h2, "running", 32'h1);
        wait_idle(4'h2);
        check("word count", 32'(got.size()), 32'h3);
        check("word 0", got[0], 32'hA000_0000);
        check("word 1", got[1], 32'hA000_0001);
        check("word 2", got[2], 32'hB000_0000);
        irq_edge(0);
        rd(4'h2, "normal end", 32'h4);
        wr(4'h2, 32'h4);
        rd(4'h2, "cleared, line high", 32'h0);
        drive_irq_i[0] <= 1'b0;
        wr(4'h0, 32'h0);
        $display("Test normal completion done");
        // Secondary, drive to memory: region larger than the drive transfer.
        far.mem[96] = 32'h0000_0380;
        far.mem[97] = 32'h8000_0010;
        far.words[1] = 2;
        wr(4'hC, 32'h0000_0180);
        wr(4'h8, 32'h0000_0009);
        repeat (300) if (far.mem[225] !== 32'hC000_0101) @(posedge clk_i);
        check("mem word 0", far.mem[224], 32'hC000_0102);
        check("mem word 1", far.mem[225], 32'hC000_0101);
        irq_edge(1);
        rd(4'hA, "early end", 32'h5);
        wr(4'h8, 32'h0);
        rd(4'hA, "stopped", 32'h4);
        wr(4'hA, 32'h4);
        drive_irq_i[1] <= 1'b0;
        $display("Test early completion done");
        // Primary, one region whose read aborts.
        far.mem[65] = 32'h8000_0004;
        far.abort_addr = 32'h0000_0200;
        far.words[0] = 1;
        wr(4'h0, 32'h1);
        wait_idle(4'h2);
        rd(4'h2, "abort", 32'h2);
        wr(4'h2, 32'h2);
        rd(4'h2, "error cleared", 32'h0);
        wr(4'h0, 32'h0);
        far.abort_addr = 32'hFFFF_FFFF;
        $display("Test abort done");
        // Descriptors cover one word while the drive wants two.
        far.words[0] = 2;
        wr(4'h0, 32'h1);
        wait_idle(4'h2);
        rd(4'h2, "short table", 32'h0);
        check("short word", got[3], 32'hA000_0000);
        far.words[0] = 0;
        wr(4'h0, 32'h0);
        $display("Test short table done");
        end_sim();
    end
    // The tests need a few hundred cycles.
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        $display("MISMATCH watchdog expected finish seen timeout");
        end_sim();
    end
endmodule : tb
bind ide_dma_engine ide_dma_properties #(.CHANNELS(CHANNELS)) u_props (.*);
`default_nettype wire
